/* File: verilog/irq_priority_level_bank_defines.vh */
// offsets, field positions, reset values and level codes of the priority bank
`ifndef IRQ_PRIORITY_LEVEL_BANK_DEFINES_VH
`define IRQ_PRIORITY_LEVEL_BANK_DEFINES_VH

// register indices; byte address is four times the index
`define DEBUG_BREAK_STEP_PRIORITY_IDX 2'h0
`define DEBUG_COMM_TRACE_PRIORITY_IDX 2'h1
`define FLASH_CLOCK_SUPPLY_LINE_PRIORITY_IDX 2'h2
`define PORT_CAN_PRIORITY_IDX 2'h3
`define REG_COUNT 4

`define PRIORITY_RESET 16'h0000

// writable bits per register; all others read zero
`define DEBUG_BREAK_STEP_MASK 16'h3C00
`define DEBUG_COMM_TRACE_MASK 16'h003F
`define FLASH_CLOCK_SUPPLY_LINE_MASK 16'hFFCF
`define PORT_CAN_MASK 16'hFFFC

// low bit of each field
`define BREAKPOINT_UNIT0_LSB 12
`define STEP_COUNTER_LSB 10
`define DEBUG_RX_FULL_LSB 4
`define DEBUG_TX_EMPTY_LSB 2
`define TRACE_BUFFER_LSB 0
`define FLASH_BUFFERS_EMPTY_LSB 14
`define FLASH_CMD_DONE_LSB 12
`define FLASH_ERROR_LSB 10
`define PLL_SLIP_LSB 8
`define LOW_SUPPLY_LSB 6
`define EXT_LINE_B_LSB 2
`define EXT_LINE_A_LSB 0
`define PORT_D_LSB 14
`define PORT_E_LSB 12
`define PORT_F_LSB 10
`define CAN_MSG_BUFFER_LSB 8
`define CAN_WAKE_LSB 6
`define CAN_FAULT_LSB 4
`define CAN_BUS_OFF_LSB 2

`define FIELD_DISABLED 2'h0
`define SOURCE_COUNT 19

`endif

/* File: verilog/priority_word_store.v */
// four-word priority store with per-word write masks and registered read data
`timescale 1ns/1ps
module priority_word_store #(
  parameter WIDTH = 16
) (
  input wire clock,
  input wire rst,
  input wire writeEn,
  input wire [1:0] writeIdx,
  input wire [WIDTH-1:0] writeData,
  input wire [1:0] readIdx,
  output reg [WIDTH-1:0] readData_r,
  output wire [4*WIDTH-1:0] allWords
);
`include "irq_priority_level_bank_defines.vh"

  reg [WIDTH-1:0] word0_r;
  reg [WIDTH-1:0] word1_r;
  reg [WIDTH-1:0] word2_r;
  reg [WIDTH-1:0] word3_r;

  // reserved bits are masked on write so they can never become set
  function [WIDTH-1:0] maskOf;
    input [1:0] idx;
    begin
      case (idx)
        `DEBUG_BREAK_STEP_PRIORITY_IDX: maskOf = `DEBUG_BREAK_STEP_MASK;
        `DEBUG_COMM_TRACE_PRIORITY_IDX: maskOf = `DEBUG_COMM_TRACE_MASK;
        `FLASH_CLOCK_SUPPLY_LINE_PRIORITY_IDX: maskOf = `FLASH_CLOCK_SUPPLY_LINE_MASK;
        default: maskOf = `PORT_CAN_MASK;
      endcase
    end
  endfunction

  assign allWords = {word3_r, word2_r, word1_r, word0_r};

  always @(posedge clock) begin
    if (rst) begin
      word0_r <= `PRIORITY_RESET; // RL4
      word1_r <= `PRIORITY_RESET; // RL4
      word2_r <= `PRIORITY_RESET; // RL4
      word3_r <= `PRIORITY_RESET; // RL4
      readData_r <= `PRIORITY_RESET;
    end else begin
      if (writeEn) begin
        case (writeIdx)
          2'h0: word0_r <= writeData & maskOf(2'h0); // RL1
          2'h1: word1_r <= writeData & maskOf(2'h1); // RL1
          2'h2: word2_r <= writeData & maskOf(2'h2); // RL8
          default: word3_r <= writeData & maskOf(2'h3); // RL12
        endcase
      end
      case (readIdx)
        2'h0: readData_r <= word0_r;
        2'h1: readData_r <= word1_r;
        2'h2: readData_r <= word2_r;
        default: readData_r <= word3_r;
      endcase
    end
  end

endmodule

/* File: verilog/irq_priority_level_bank.v */
// apb register bank of source priority fields with decoded enables and levels
//
// Summary of operation
// (RL1) reserved bits read zero and ignore writes in all four registers.
// (RL2) debug fields: 00 disabled, 01..11 give levels 1..3.
// (RL3) peripheral fields: 00 disabled, 01..11 give levels 0..2.
// (RL4) reset clears every priority field, all sources disabled.
// (RL5) register 0: breakpoint unit bits 13:12, step counter bits 11:10.
// (RL6) register 1: rx full 5:4, tx empty 3:2, trace buffer 1:0.
// (RL7) register 2: flash buffers empty 15:14, command done 13:12, error 11:10.
// (RL8) register 2: pll slip 9:8, low supply 7:6; bits 5:4 reserved.
// (RL9) register 2: external line b 3:2, external line a 1:0.
// (RL10) register 3: port d 15:14, port e 13:12, port f 11:10.
// (RL11) register 3: can message buffer 9:8, can wake 7:6.
// (RL12) register 3: can fault 5:4, can bus off 3:2; bits 1:0 reserved.
// (RL13) each source offers enable and level; zero field never offered.
`timescale 1ns/1ps
module irq_priority_level_bank #(
  parameter ADDR_WIDTH = 12
) (
  input wire clock,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_WIDTH-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg [18:0] sourceEnable,
  output reg [37:0] sourceLevel
);
`include "irq_priority_level_bank_defines.vh"

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  wire [ADDR_WIDTH-1:0] wordAddr;
  wire hit;
  wire setupPhase;
  wire storeWrite;
  wire [15:0] storeRead;
  wire [63:0] words;
  reg pendingRead_r;
  reg pendingHit_r;
  reg pendingAccess_r;
  reg [15:0] mergedData;

  assign wordAddr = paddr >> 2;
  // only the four aligned words answer; anything else is slverr
  assign hit = (paddr[1:0] == 2'h0) && (wordAddr < `REG_COUNT);
  assign setupPhase = psel && !penable;
  // write on setup edge so the store updates one edge before pready rises
  assign storeWrite = setupPhase && pwrite && hit;

  // byte strobes merge into the current word; upper 16 bits are absent
  always @* begin
    mergedData = words[paddr[3:2]*16 +: 16];
    if (pstrb[0]) begin
      mergedData[7:0] = pwdata[7:0];
    end
    if (pstrb[1]) begin
      mergedData[15:8] = pwdata[15:8];
    end
  end

  priority_word_store #(
    .WIDTH(16)
  ) store (
    .clock(clock),
    .rst(rst),
    .writeEn(storeWrite),
    .writeIdx(paddr[3:2]),
    .writeData(mergedData),
    .readIdx(paddr[3:2]),
    .readData_r(storeRead),
    .allWords(words)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb answer: one wait state, pready in the second access cycle

  always @(posedge clock) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      pendingRead_r <= 1'b0;
      pendingHit_r <= 1'b0;
      pendingAccess_r <= 1'b0;
    end else begin
      // the wait state gives the registered store output time to settle
      pendingAccess_r <= setupPhase;
      pready <= pendingAccess_r;
      pslverr <= pendingAccess_r && !pendingHit_r;
      pendingRead_r <= setupPhase && !pwrite;
      pendingHit_r <= hit;
    end
  end

  // read data stands with pready only, zero padded above
  always @(posedge clock) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (pendingAccess_r && pendingRead_r && pendingHit_r) begin
      prdata <= {16'h0000, storeRead}; // RL1
    end else begin
      prdata <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field decode toward arbitration

  // debug sources sit one level higher than peripherals
  function [1:0] levelOf;
    input [1:0] code;
    input debugSrc;
    begin
      if (debugSrc) begin
        levelOf = code; // RL2
      end else begin
        levelOf = code - 2'h1; // RL3
      end
    end
  endfunction

  function [1:0] fieldAt;
    input [15:0] word;
    input integer lsb;
    begin
      fieldAt = word[lsb +: 2];
    end
  endfunction

  wire [15:0] w0 = words[15:0];
  wire [15:0] w1 = words[31:16];
  wire [15:0] w2 = words[47:32];
  wire [15:0] w3 = words[63:48];
  reg [37:0] codes;
  reg [37:0] levelNxt;
  reg [18:0] enableNxt;
  integer i;

  always @* begin
    codes = {
      fieldAt(w0, `BREAKPOINT_UNIT0_LSB), // RL5
      fieldAt(w0, `STEP_COUNTER_LSB), // RL5
      fieldAt(w1, `DEBUG_RX_FULL_LSB), // RL6
      fieldAt(w1, `DEBUG_TX_EMPTY_LSB), // RL6
      fieldAt(w1, `TRACE_BUFFER_LSB), // RL6
      fieldAt(w2, `FLASH_BUFFERS_EMPTY_LSB), // RL7
      fieldAt(w2, `FLASH_CMD_DONE_LSB), // RL7
      fieldAt(w2, `FLASH_ERROR_LSB), // RL7
      fieldAt(w2, `PLL_SLIP_LSB), // RL8
      fieldAt(w2, `LOW_SUPPLY_LSB), // RL8
      fieldAt(w2, `EXT_LINE_B_LSB), // RL9
      fieldAt(w2, `EXT_LINE_A_LSB), // RL9
      fieldAt(w3, `PORT_D_LSB), // RL10
      fieldAt(w3, `PORT_E_LSB), // RL10
      fieldAt(w3, `PORT_F_LSB), // RL10
      fieldAt(w3, `CAN_MSG_BUFFER_LSB), // RL11
      fieldAt(w3, `CAN_WAKE_LSB), // RL11
      fieldAt(w3, `CAN_FAULT_LSB), // RL12
      fieldAt(w3, `CAN_BUS_OFF_LSB) // RL12
    };
    levelNxt = 38'h0;
    enableNxt = 19'h0;
    for (i = 0; i < `SOURCE_COUNT; i = i + 1) begin
      enableNxt[i] = codes[2*i +: 2] != `FIELD_DISABLED; // RL13
      // disabled sources show level zero so nothing stale leaks out
      if (enableNxt[i]) begin
        levelNxt[2*i +: 2] = levelOf(codes[2*i +: 2], i >= 14); // RL13
      end
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      sourceEnable <= 19'h0; // RL4
      sourceLevel <= 38'h0;
    end else begin
      sourceEnable <= enableNxt;
      sourceLevel <= levelNxt;
    end
  end

endmodule

/* File: sim/irq_priority_level_bank_monitor.sv */
// port assertions for the priority bank
`timescale 1ns/1ps
module irq_priority_level_bank_monitor #(parameter ADDR_WIDTH = 12) (
  input wire clock,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_WIDTH-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [18:0] sourceEnable,
  input wire [37:0] sourceLevel
);
  logic offBad, dbgBad, perBad;
  integer i;
  wire rdOk = psel && pready && !pwrite && !pslverr;
  always_comb begin
    offBad = 0;
    dbgBad = 0;
    perBad = 0;
    for (i = 0; i < 19; i++) begin
      if (!sourceEnable[i] && sourceLevel[2*i+:2] != 0) offBad = 1;
      if (sourceEnable[i] && i > 13 && sourceLevel[2*i+:2] == 0) dbgBad = 1;
      if (sourceEnable[i] && i < 14 && sourceLevel[2*i+:2] == 3) perBad = 1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  rst_clear_a: assert property (disable iff (1'b0) rst |=> !sourceEnable && !sourceLevel && !prdata)
    else $error("outputs not cleared by reset");
  rd_upper_a: assert property (pready |-> prdata[31:16] == 0)
    else $error("upper read bits set");
  res_zero_a: assert property (rdOk && paddr == 0 |-> (prdata & 32'hC3FF) == 0)
    else $error("reserved bits set in word 0");
  res_one_a: assert property (rdOk && paddr == 4 |-> (prdata & 32'hFFC0) == 0)
    else $error("reserved bits set in word 1");
  res_two_a: assert property (rdOk && paddr == 8 |-> prdata[5:4] == 0)
    else $error("reserved bits set in word 2");
  res_three_a: assert property (rdOk && paddr == 12 |-> prdata[1:0] == 0)
    else $error("reserved bits set in word 3");
  map_zero_a: assert property (pready && pwrite && !pslverr && paddr == 0 && pstrb[1]
    |-> sourceLevel[37:34] == pwdata[13:10])
    else $error("debug break or step level wrong");
  off_level_a: assert property (!offBad)
    else $error("disabled source shows a level");
  dbg_level_a: assert property (!dbgBad)
    else $error("debug source at level zero");
  per_level_a: assert property (!perBad)
    else $error("peripheral source at level three");
endmodule
bind irq_priority_level_bank irq_priority_level_bank_monitor #(.ADDR_WIDTH(ADDR_WIDTH)) mon_i (
  .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sourceEnable(sourceEnable), .sourceLevel(sourceLevel));

/* File: sim/irq_arbiter_model.sv */
// arbitration-side model that sees the offered sources
`timescale 1ns/1ps
module irq_arbiter_model (
  input wire [18:0] sourceEnable,
  input wire [37:0] sourceLevel,
  output reg anyReq,
  output reg [1:0] topLevel
);
  integer i;
  // a disabled source never competes, whatever its level bits say
  always @* begin
    anyReq = 1'b0;
    topLevel = 2'h0;
    for (i = 0; i < 19; i++) begin
      if (sourceEnable[i]) anyReq = 1'b1;
      if (sourceEnable[i] && sourceLevel[2*i+:2] > topLevel) topLevel = sourceLevel[2*i+:2];
    end
  end
endmodule

/* File: sim/test_irq_priority_level_bank.sv */
// self-checking bench of the priority bank against a field model
`timescale 1ns/1ps
module test_irq_priority_level_bank;
  reg clock = 0;
  reg rst = 1;
  reg psel = 0;
  reg penable = 0;
  reg pwrite = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0;
  reg [3:0] pstrb = 0;
  wire [31:0] prdata;
  wire pready, pslverr, anyReq;
  wire [18:0] sourceEnable;
  wire [37:0] sourceLevel;
  wire [1:0] topLevel;
  reg [31:0] rd;
  reg er;
  reg [15:0] m [4];
  reg [15:0] msk [4] = '{16'h3C00, 16'h003F, 16'hFFCF, 16'hFFFC};
  integer bad_count = 0;
  integer n_compared = 0;
  integer k, r, a;
  irq_priority_level_bank irq_priority_level_bank_i (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sourceEnable(sourceEnable), .sourceLevel(sourceLevel));
  irq_arbiter_model irq_arbiter_model_i (.sourceEnable(sourceEnable), .sourceLevel(sourceLevel),
    .anyReq(anyReq), .topLevel(topLevel));
  initial begin
    forever #50 clock = ~clock;
  end
  ////////////////////////////////////////
  task chk(input string nm, input [63:0] seen, input [63:0] exp);
    begin
      n_compared++;
      if (seen !== exp) begin
        bad_count++;
        $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  function mp(input [11:0] ad);
    mp = ad < 16 && ad[1:0] == 0;
  endfunction
  // no cycle count assumed: wait on pready, bounded
  task apb(input w, input [11:0] ad, input [31:0] d, input [3:0] s);
    integer n;
    begin
      n = 0;
      @(posedge clock);
      psel <= 1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      pstrb <= s;
      @(posedge clock);
      penable <= 1;
      do begin
        @(posedge clock);
        n++;
      end while (pready !== 1'b1 && n < 40);
      if (pready !== 1'b1) bad_count++;
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
    end
  endtask
  task wr(input [11:0] ad, input [31:0] d, input [3:0] s);
    reg [15:0] wm;
    begin
      wm = {{8{s[1]}}, {8{s[0]}}};
      apb(1, ad, d, s);
      chk("werr", er, !mp(ad));
      if (mp(ad)) m[ad[3:2]] = (m[ad[3:2]] & ~wm) | (d[15:0] & wm & msk[ad[3:2]]);
    end
  endtask
  task rdchk(input [11:0] ad);
    begin
      apb(0, ad, 32'h0, 4'h0);
      chk("rerr", er, !mp(ad));
      chk("rdata", rd, mp(ad) ? m[ad[3:2]] : 0);
    end
  endtask
  // fields walked high bit first, word 0 up, give sources 18 down to 0
  task cmpall;
    integer w, b, i;
    reg [1:0] c, v, t;
    reg [18:0] e;
    reg [37:0] l;
    begin
      i = 18;
      e = 0;
      l = 0;
      t = 0;
      for (w = 0; w < 4; w++) for (b = 14; b >= 0; b -= 2) if (msk[w][b]) begin
        c = m[w] >> b;
        v = c == 0 ? 0 : w < 2 ? c : c - 1;
        e[i] = c != 0;
        l[2*i+:2] = v;
        if (c != 0 && v > t) t = v;
        i--;
      end
      chk("enable", sourceEnable, e);
      chk("level", sourceLevel, l);
      chk("any", anyReq, e != 0);
      chk("top", topLevel, t);
    end
  endtask
  task rdall;
    begin
      for (r = 0; r < 4; r++) rdchk({r[9:0], 2'h0});
      cmpall;
    end
  endtask
  task give_verdict;
    begin
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    #3000000;
    bad_count++;
    give_verdict;
  end
  initial begin
    void'($urandom(85));
    for (k = 0; k < 4; k++) m[k] = 0;
    repeat (16) @(posedge clock);
    rst <= 0;
    rdall;
    for (k = 0; k < 4; k++) begin
      for (r = 0; r < 4; r++) wr({r[9:0], 2'h0}, k * 32'h5555, 4'hF);
      rdall;
    end
    for (k = 0; k < 40; k++) begin
      a = ($urandom % 5) * 4 + ($urandom % 6 == 0);
      wr(a[11:0], $urandom, $urandom % 16);
      rdchk(a[11:0]);
      cmpall;
    end
    rst <= 1;
    repeat (2) @(posedge clock);
    rst <= 0;
    for (k = 0; k < 4; k++) m[k] = 0;
    rdall;
    give_verdict;
  end
endmodule
